// ===== design/rcc_pkg.sv
package rcc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [14:0] ADDR_CONTROL     = 15'h7FF8;
  localparam logic [14:0] ADDR_SECONDS     = 15'h7FF9;
  localparam logic [14:0] ADDR_CENTURY_DAY = 15'h7FFC;

  localparam int CTL_LOAD_BIT   = 7;
  localparam int CTL_FREEZE_BIT = 6;
  localparam int CTL_SIGN_BIT   = 5;
  localparam int CTL_MAG_MSB    = 4;
  localparam int SEC_HALT_BIT   = 7;
  localparam int DAY_TEST_BIT   = 6;
  localparam int DAY_CENT_EN    = 5;
  localparam int DAY_CENT_BIT   = 4;
  localparam int DAY_DAY_MSB    = 2;

  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic       HALT_RESET    = 1'h1;
  localparam logic [6:0] SECONDS_RESET = 7'h00;
  localparam logic [7:0] DAY_RESET     = 8'h01;

  // ----------------------------------------------------------------
  // Oscillator chain
  // ----------------------------------------------------------------
  localparam int OSC_HZ     = 32768;
  localparam int TEST_HZ    = 512;
  localparam int STAGE_DIV  = 256;
  localparam int NEG_EXTRA  = 128;
  localparam logic [8:0] STAGE_LAST      = 9'(STAGE_DIV - 1);
  localparam logic [8:0] STAGE_LAST_SLOW = 9'(STAGE_DIV + NEG_EXTRA - 1);
  localparam logic [6:0] PULSES_LAST     = 7'(OSC_HZ / STAGE_DIV - 1);
  localparam logic [6:0] PULSE_STEP      = 7'h01;
  localparam logic [6:0] PULSE_SPLIT     = 7'h02;
  localparam int TEST_BIT = $clog2(OSC_HZ / TEST_HZ) - 1;
  localparam logic [5:0] SEC_LAST   = 6'h3B;
  localparam logic [5:0] MOD_SECOND = 6'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [14:0] addr;
    logic [7:0]  data;
  } rcc_bus_t;

  typedef struct packed {
    logic [7:0]  control;
    logic        halt;
    logic [6:0]  sec_image;
    logic [7:0]  day_reg;
    logic [8:0]  stage1;
    logic [6:0]  stage2;
    logic [5:0]  sec_cnt;
    logic [5:0]  cycle_min;
    logic [5:0]  raw_cnt;
    logic        wr_pend;
    logic [14:0] wr_addr;
    logic [7:0]  wr_data;
    logic        load_prev;
    logic [7:0]  dq_out;
    logic        dq_oe;
    logic        second_tick;
    logic        minute_tick;
  } rcc_state_t;

endpackage

// ===== design/rcc_calib_century.sv
`timescale 1ns/1ps
module rcc_calib_century (
  input  wire logic              clk,              // 250 MHz clock
  input  wire logic              srst,             // Synchronous reset, active high
  input  wire rcc_pkg::rcc_bus_t bus_in,           // Byte-wide bus pins
  input  wire logic              osc_tick,         // One-cycle pulse per crystal period
  input  wire logic              century_rollover, // One-cycle pulse at the turn of a century
  input  wire logic              power_down,       // High while supply is failing
  output logic [7:0]             dq_out,           // Data driven onto the bus
  output logic                   dq_oe,            // High while the block drives data
  output logic                   second_tick,      // Corrected one-second pulse
  output logic                   minute_tick       // Corrected one-minute pulse
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] to_bcd(input logic [5:0] bin);
    logic [3:0] tens;
    logic [5:0] ones;
    tens = 4'h0;
    ones = bin;
    for (int i = 0; i < 5; i++)
    begin
      if (ones >= 6'h0A)
      begin
        ones = ones - 6'h0A;
        tens = tens + 4'h1;
      end
    end
    return {tens[2:0], ones[3:0]};
  endfunction

  function automatic logic [5:0] from_bcd(input logic [6:0] bcd);
    logic [5:0] val;
    val = 6'({3'h0, bcd[6:4]} * 6'h0A) + {2'h0, bcd[3:0]};
    if (val > rcc_pkg::SEC_LAST)
    begin
      val = 6'h00;
    end
    return val;
  endfunction

  function automatic logic in_map(input logic [14:0] a);
    return (a == rcc_pkg::ADDR_CONTROL) || (a == rcc_pkg::ADDR_SECONDS) ||
           (a == rcc_pkg::ADDR_CENTURY_DAY);
  endfunction

  rcc_pkg::rcc_state_t state_reg;
  rcc_pkg::rcc_state_t state_next;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic       osc_run;
    logic       wr_active;
    logic       commit;
    logic       rd_active;
    logic       frozen;
    logic       loading;
    logic [4:0] mag;
    logic       corr;
    logic       stage_pulse;
    logic       sec_pulse;
    logic [6:0] step;
    logic [8:0] stage_last;
    logic [7:0] rd_data;
    logic [5:0] sec_new;

    state_next = state_reg;
    state_next.second_tick = 1'b0;
    state_next.minute_tick = 1'b0;

    osc_run = osc_tick && !state_reg.halt;
    mag     = state_reg.control[rcc_pkg::CTL_MAG_MSB:0];
    frozen  = state_reg.control[rcc_pkg::CTL_LOAD_BIT] || state_reg.control[rcc_pkg::CTL_FREEZE_BIT];
    loading = state_reg.load_prev && !state_reg.control[rcc_pkg::CTL_LOAD_BIT];
    state_next.load_prev = state_reg.control[rcc_pkg::CTL_LOAD_BIT];

    // Second zero of each of the first 2n minutes is the modified one
    corr = (mag != 5'h00) && (state_reg.cycle_min < {mag, 1'b0}) &&
           (state_reg.sec_cnt == rcc_pkg::MOD_SECOND);
    // Only the first stage period of the second is stretched or split
    stage_last = (corr && !state_reg.control[rcc_pkg::CTL_SIGN_BIT] && state_reg.stage2 == 7'h00) ?
                 rcc_pkg::STAGE_LAST_SLOW : rcc_pkg::STAGE_LAST;
    step = (corr && state_reg.control[rcc_pkg::CTL_SIGN_BIT] && state_reg.stage2 == 7'h00) ?
           rcc_pkg::PULSE_SPLIT : rcc_pkg::PULSE_STEP;

    // ----------------------------------------------------------------
    // Divider chain
    // ----------------------------------------------------------------
    stage_pulse = 1'b0;
    sec_pulse   = 1'b0;
    if (osc_run)
    begin
      state_next.raw_cnt = state_reg.raw_cnt + 6'h01;
      if (state_reg.stage1 >= stage_last)
      begin
        state_next.stage1 = 9'h000;
        stage_pulse = 1'b1;
      end
      else
      begin
        state_next.stage1 = state_reg.stage1 + 9'h001;
      end
    end
    if (stage_pulse)
    begin
      if (state_reg.stage2 == rcc_pkg::PULSES_LAST)
      begin
        state_next.stage2 = 7'h00;
        sec_pulse = 1'b1;
      end
      else
      begin
        state_next.stage2 = state_reg.stage2 + step;
      end
    end
    sec_new = state_reg.sec_cnt;
    if (sec_pulse)
    begin
      state_next.second_tick = 1'b1;
      if (state_reg.sec_cnt == rcc_pkg::SEC_LAST)
      begin
        sec_new = 6'h00;
        state_next.minute_tick = 1'b1;
        state_next.cycle_min = state_reg.cycle_min + 6'h01;
      end
      else
      begin
        sec_new = state_reg.sec_cnt + 6'h01;
      end
      state_next.sec_cnt = sec_new;
      if (!frozen)
      begin
        state_next.sec_image = to_bcd(sec_new);
      end
    end
    // Restarting the divider makes the next tick land one full divider second (32768 ticks unless corrected) after the load
    if (loading)
    begin
      state_next.sec_cnt = from_bcd(state_reg.sec_image);
      state_next.stage1  = 9'h000;
      state_next.stage2  = 7'h00;
    end

    // ----------------------------------------------------------------
    // Bus writes, committed when the write strobe ends
    // ----------------------------------------------------------------
    wr_active = !bus_in.ce_n && !bus_in.we_n && !power_down;
    commit    = state_reg.wr_pend && !wr_active;
    state_next.wr_pend = wr_active;
    if (wr_active)
    begin
      state_next.wr_addr = bus_in.addr;
      state_next.wr_data = bus_in.data;
    end
    if (commit)
    begin
      unique case (state_reg.wr_addr)
        rcc_pkg::ADDR_CONTROL:
        begin
          state_next.control = state_reg.wr_data;
        end
        rcc_pkg::ADDR_SECONDS:
        begin
          state_next.halt      = state_reg.wr_data[rcc_pkg::SEC_HALT_BIT];
          state_next.sec_image = state_reg.wr_data[6:0];
        end
        rcc_pkg::ADDR_CENTURY_DAY:
        begin
          state_next.day_reg[rcc_pkg::DAY_TEST_BIT] = state_reg.wr_data[rcc_pkg::DAY_TEST_BIT];
          state_next.day_reg[rcc_pkg::DAY_CENT_EN]  = state_reg.wr_data[rcc_pkg::DAY_CENT_EN];
          state_next.day_reg[rcc_pkg::DAY_DAY_MSB:0] = state_reg.wr_data[rcc_pkg::DAY_DAY_MSB:0];
          if (state_reg.control[rcc_pkg::CTL_LOAD_BIT])
          begin
            state_next.day_reg[rcc_pkg::DAY_CENT_BIT] = state_reg.wr_data[rcc_pkg::DAY_CENT_BIT];
          end
        end
        default:
        begin
        end
      endcase
    end

    // Rollover toggles after any write in the same cycle, so it is never lost
    if (century_rollover && state_next.day_reg[rcc_pkg::DAY_CENT_EN])
    begin
      state_next.day_reg[rcc_pkg::DAY_CENT_BIT] = !state_next.day_reg[rcc_pkg::DAY_CENT_BIT];
    end
    if (power_down)
    begin
      state_next.day_reg[rcc_pkg::DAY_TEST_BIT] = 1'b0;
    end

    // ----------------------------------------------------------------
    // Bus reads; addresses outside the map are left to the memory array
    // ----------------------------------------------------------------
    rd_active = !bus_in.ce_n && !bus_in.oe_n && bus_in.we_n && !power_down && in_map(bus_in.addr);
    rd_data = 8'h00;
    unique case (bus_in.addr)
      rcc_pkg::ADDR_CONTROL:
      begin
        rd_data = state_reg.control;
      end
      rcc_pkg::ADDR_SECONDS:
      begin
        rd_data = {state_reg.halt, state_reg.sec_image};
        if (state_reg.day_reg[rcc_pkg::DAY_TEST_BIT] && !state_reg.halt)
        begin
          rd_data[0] = state_reg.raw_cnt[rcc_pkg::TEST_BIT];
        end
      end
      rcc_pkg::ADDR_CENTURY_DAY:
      begin
        rd_data = {1'b0, state_reg.day_reg[6:4], 1'b0, state_reg.day_reg[2:0]};
      end
      default:
      begin
        rd_data = 8'h00;
      end
    endcase
    state_next.dq_oe  = rd_active;
    state_next.dq_out = rd_active ? rd_data : 8'h00;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg           <= '0;
      state_reg.control   <= rcc_pkg::CONTROL_RESET;
      state_reg.halt      <= rcc_pkg::HALT_RESET;
      state_reg.sec_image <= rcc_pkg::SECONDS_RESET;
      state_reg.day_reg   <= rcc_pkg::DAY_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign dq_out      = state_reg.dq_out;
  assign dq_oe       = state_reg.dq_oe;
  assign second_tick = state_reg.second_tick;
  assign minute_tick = state_reg.minute_tick;

endmodule

// ===== verification/rcc_calib_century_props.sv
`timescale 1ns/1ps
module rcc_calib_century_props (
  input wire logic              clk,              // Clock
  input wire logic              srst,             // Reset
  input wire rcc_pkg::rcc_bus_t bus_in,           // Bus pins
  input wire logic              osc_tick,         // Crystal tick
  input wire logic              century_rollover, // Century turn
  input wire logic              power_down,       // Supply failing
  input wire logic [7:0]        dq_out,           // Read data
  input wire logic              dq_oe,            // Data drive
  input wire logic              second_tick,      // Second pulse
  input wire logic              minute_tick       // Minute pulse
);
  logic rd_c;
  assign rd_c = !bus_in.ce_n && !bus_in.oe_n && bus_in.we_n && !power_down
    && (bus_in.addr == rcc_pkg::ADDR_CONTROL || bus_in.addr == rcc_pkg::ADDR_SECONDS
    || bus_in.addr == rcc_pkg::ADDR_CENTURY_DAY);
  default clocking cyc @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence s_read;
    rd_c;
  endsequence
  sequence s_quiet;
    !second_tick [*8];
  endsequence
  AST_RD_DRIVE: assert property (s_read |=> dq_oe) else $error("read not driven");
  AST_RD_IDLE: assert property (!rd_c |=> !dq_oe) else $error("drive without read");
  AST_PD_QUIET: assert property (power_down |=> !dq_oe && dq_out == 8'h00) else $error("drive in power-down");
  AST_OUT_ZERO: assert property (!dq_oe |-> dq_out == 8'h00) else $error("data while released");
  AST_SEC_PULSE: assert property (second_tick |=> s_quiet) else $error("second pulses too close");
  AST_MIN_PULSE: assert property (minute_tick |=> !minute_tick [*8]) else $error("minute pulses too close");
  AST_MIN_SEC: assert property (minute_tick |-> second_tick) else $error("minute without second");
  AST_RST_QUIET: assert property ($fell(srst) |-> !dq_oe && !second_tick) else $error("active after reset");
endmodule
bind rcc_calib_century rcc_calib_century_props u_props (.clk(clk), .srst(srst), .bus_in(bus_in),
  .osc_tick(osc_tick), .century_rollover(century_rollover), .power_down(power_down), .dq_out(dq_out),
  .dq_oe(dq_oe), .second_tick(second_tick), .minute_tick(minute_tick));

// ===== verification/rcc_host_model.sv
`timescale 1ns/1ps
module rcc_host_model (
  input  wire logic         clk,    // Clock
  input  wire logic [7:0]   dq_out, // Read data
  input  wire logic         dq_oe,  // Data drive
  output rcc_pkg::rcc_bus_t bus     // Bus pins
);
  initial bus = '{ce_n:1'b1, we_n:1'b1, oe_n:1'b1, addr:15'h0000, data:8'h00};
  // Released lines flip so no stale value can pass for a real one
  task automatic idle();
    bus <= '{ce_n:1'b1, we_n:1'b1, oe_n:1'b1, addr:~bus.addr, data:~bus.data};
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{ce_n:1'b0, we_n:1'b0, oe_n:1'b1, addr:a, data:d};
    @(posedge clk);
    idle();
    @(posedge clk);
  endtask
  task automatic rd(input logic [14:0] a, output logic [7:0] d, output logic oe);
    @(posedge clk);
    bus <= '{ce_n:1'b0, we_n:1'b1, oe_n:1'b0, addr:a, data:~bus.data};
    @(posedge clk);
    @(posedge clk);
    d = dq_out;
    oe = dq_oe;
    idle();
  endtask
  task automatic rd_hold(input logic [14:0] a, input int n, output int tg);
    logic p;
    tg = 0;
    @(posedge clk);
    bus <= '{ce_n:1'b0, we_n:1'b1, oe_n:1'b0, addr:a, data:~bus.data};
    repeat (2) @(posedge clk);
    p = dq_out[0];
    repeat (n)
    begin
      @(posedge clk);
      if (dq_out[0] !== p) tg++;
      p = dq_out[0];
    end
    idle();
  endtask
endmodule

// ===== verification/rcc_calib_century_tb.sv
`timescale 1ns/1ps
module rcc_calib_century_tb;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic              osc_tick = 1'b0;
  logic              century_rollover = 1'b0;
  logic              power_down = 1'b0;
  rcc_pkg::rcc_bus_t bus;
  logic [7:0]        dq_out;
  logic              dq_oe;
  logic              second_tick;
  logic              minute_tick;
  logic [7:0]        d;
  logic              oe;
  int                failures = 0;
  int                compares = 0;
  int                tg;
  time               t0;
  always #2 clk = ~clk;
  rcc_host_model u_host (.clk(clk), .dq_out(dq_out), .dq_oe(dq_oe), .bus(bus));
  rcc_calib_century u_dut (.clk(clk), .srst(srst), .bus_in(bus), .osc_tick(osc_tick),
    .century_rollover(century_rollover), .power_down(power_down), .dq_out(dq_out), .dq_oe(dq_oe),
    .second_tick(second_tick), .minute_tick(minute_tick));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [14:0] a, input logic [7:0] exp);
    u_host.rd(a, d, oe);
    chk({7'h00, oe}, 8'h01);
    chk(d, exp);
  endtask
  task automatic roll();
    @(posedge clk);
    century_rollover <= 1'b1;
    @(posedge clk);
    century_rollover <= 1'b0;
  endtask
  // Bounded wait; detection lags the pulse by one edge, equal for every call
  task automatic wait_sec();
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (second_tick !== 1'b1 && k < 40000);
  endtask
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #(4 * 80000);
    failures++;
    $display("ERROR %0t: watchdog expired", $time);
    close_out();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    osc_tick <= 1'b1;
    rchk(rcc_pkg::ADDR_CONTROL, 8'h00);
    rchk(rcc_pkg::ADDR_SECONDS, 8'h80);
    rchk(rcc_pkg::ADDR_CENTURY_DAY, 8'h01);
    u_host.wr(15'h7FF0, 8'h55);
    u_host.rd(15'h7FF0, d, oe);
    chk({7'h00, oe}, 8'h00);
    u_host.wr(rcc_pkg::ADDR_CONTROL, 8'h25);
    rchk(rcc_pkg::ADDR_CONTROL, 8'h25);
    u_host.wr(rcc_pkg::ADDR_CENTURY_DAY, 8'h30);
    rchk(rcc_pkg::ADDR_CENTURY_DAY, 8'h20);
    u_host.wr(rcc_pkg::ADDR_CONTROL, 8'hA1);
    u_host.wr(rcc_pkg::ADDR_CENTURY_DAY, 8'h30);
    rchk(rcc_pkg::ADDR_CENTURY_DAY, 8'h30);
    roll();
    rchk(rcc_pkg::ADDR_CENTURY_DAY, 8'h20);
    u_host.wr(rcc_pkg::ADDR_CENTURY_DAY, 8'h10);
    roll();
    rchk(rcc_pkg::ADDR_CENTURY_DAY, 8'h10);
    // Image second 59 so the first counted second also closes a minute
    u_host.wr(rcc_pkg::ADDR_SECONDS, 8'h59);
    u_host.wr(rcc_pkg::ADDR_CENTURY_DAY, 8'h40);
    u_host.wr(rcc_pkg::ADDR_CONTROL, 8'h21);
    t0 = $time;
    // Wave period is 64 ticks, so 640 cycles hold about 20 edges
    u_host.rd_hold(rcc_pkg::ADDR_SECONDS, 640, tg);
    chk(8'(tg >= 19 && tg <= 21), 8'h01);
    @(posedge clk);
    power_down <= 1'b1;
    repeat (4) @(posedge clk);
    power_down <= 1'b0;
    rchk(rcc_pkg::ADDR_CENTURY_DAY, 8'h00);
    u_host.wr(rcc_pkg::ADDR_CENTURY_DAY, 8'h40);
    u_host.wr(rcc_pkg::ADDR_CENTURY_DAY, 8'h00);
    rchk(rcc_pkg::ADDR_CENTURY_DAY, 8'h00);
    // Load restarts the divider one edge after the commit, detection adds one more
    wait_sec();
    chk(8'((($time - t0) / 4) == 32770), 8'h01);
    chk({7'h00, minute_tick}, 8'h01);
    t0 = $time;
    // Second zero of corrected minute one is still inside the first 2n minutes
    wait_sec();
    chk(8'((($time - t0) / 4) >= 32505 && (($time - t0) / 4) <= 32520), 8'h01);
    close_out();
  end
endmodule
